// [pti_pointer_interp.sv]
// receive payload pointer interpreter with APB register slave
`timescale 1ns/10ps
module pti_pointer_interp
  import pti_pkg::*;
(
  input  wire logic        pclk,               // 250 MHz clock
  input  wire logic        presetn,            // async reset
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB direction
  input  wire logic [7:0]  paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error
  input  wire logic        h_valid,            // pointer pair strobe
  input  wire logic        h_first,            // first pair of frame
  input  wire logic [15:0] h_word,             // H1 in [15:8]
  input  wire logic        frame_tick,         // all pairs received
  output logic             wan_irq_out_a,      // interrupt A
  output logic             wan_irq_out_b,      // interrupt B
  output logic [1:0]       ptr_state,          // interpreter state
  output logic [9:0]       ptr_value,          // accepted pointer
  output logic             path_ais_alarm,     // AIS status
  output logic             pointer_loss_alarm  // LOP status
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] pti_ones(input logic [9:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < 10; k++) begin
      c = c + {3'h0, v[k]};
    end
    return c;
  endfunction

  // three of four flag bits agree with the code
  function automatic logic pti_flag(input logic [3:0] f,
                                    input logic [3:0] p);
    return pti_ones({6'h00, ~(f ^ p)}) >= PTI_FLAG_AGREE;
  endfunction

  function automatic logic pti_hit(input logic [7:0] a,
                                   input logic [7:0] o);
    return a == o;
  endfunction

  pti_regs_type r_reg;
  pti_regs_type r_next;

  logic [3:0]   flg;
  logic [1:0]   ss;
  logic [9:0]   off;
  logic         ss_ok;
  logic         is_ais;
  logic         in_rng;
  logic         norm_ok;
  logic         ndf_ok;
  logic [9:0]   diff;
  logic [3:0]   i_inv;
  logic [3:0]   d_inv;
  logic         son_inc;
  logic         son_dec;
  logic         sdh_inc;
  logic         sdh_dec;
  logic         jst_ok;
  logic         inc_ok;
  logic         dec_ok;
  logic         norm_same;
  logic         ptr_valid;
  logic         ci_ok;
  logic [7:0]   pair_lim;
  logic         setup;
  logic         done;
  logic         wr;
  logic         rd;
  logic         mapped;
  logic         ais_evt;
  logic         lop_evt;
  logic [1:0]   evt;
  logic [1:0]   stat_now;
  logic         irq_a_want;
  logic         irq_b_want;

  // ----------------------------------------------------------------
  // pointer classification
  // ----------------------------------------------------------------
  assign flg    = r_reg.prim_word[PTI_FLAG_MSB:PTI_FLAG_LSB];
  assign ss     = r_reg.prim_word[PTI_SS_MSB:PTI_SS_LSB];
  assign off    = r_reg.prim_word[PTI_OFF_MSB:0];
  assign ss_ok  = !r_reg.sdh || (ss == PTI_SS_SDH);
  assign is_ais = r_reg.prim_word == PTI_AIS_WORD;
  assign in_rng = off <= PTI_OFF_MAX;
  // a bad concatenation indication spoils the normal, new-data and justification pointers of the frame, but not an AIS word
  assign norm_ok = pti_flag(flg, PTI_FLAG_NORM) && ss_ok
                   && in_rng && !r_reg.concat_pointer_bad;
  assign ndf_ok  = pti_flag(flg, PTI_FLAG_NDF) && ss_ok
                   && in_rng && !r_reg.concat_pointer_bad;

  assign diff    = off ^ r_reg.cur_ptr;
  assign i_inv   = pti_ones(diff & PTI_I_MASK);
  assign d_inv   = pti_ones(diff & PTI_D_MASK);
  // at most two disagreeing bits means eight of ten agree
  assign son_inc = pti_ones(diff ^ PTI_I_MASK)
                   <= (PTI_OFF_BITS - PTI_SONET_AGREE);
  assign son_dec = pti_ones(diff ^ PTI_D_MASK)
                   <= (PTI_OFF_BITS - PTI_SONET_AGREE);
  assign sdh_inc = (i_inv >= PTI_SDH_MAJ)
                   && (d_inv <= PTI_SDH_MIN);
  assign sdh_dec = (d_inv >= PTI_SDH_MAJ)
                   && (i_inv <= PTI_SDH_MIN);
  assign jst_ok  = pti_flag(flg, PTI_FLAG_NORM) && ss_ok
                   && !r_reg.concat_pointer_bad && (r_reg.state == PTI_NORM)
                   && (r_reg.hold_cnt == 2'h0);
  assign inc_ok  = jst_ok && (r_reg.sdh ? sdh_inc : son_inc);
  assign dec_ok  = jst_ok && (r_reg.sdh ? sdh_dec : son_dec);
  assign norm_same = norm_ok && (off == r_reg.cur_ptr);

  always_comb begin
    unique case (r_reg.state)
      PTI_AIS:  ptr_valid = is_ais;
      PTI_NORM: ptr_valid = ndf_ok || norm_same
                            || inc_ok || dec_ok;
      PTI_LOP:  ptr_valid = 1'b0;
      default:  ptr_valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // concatenation indications
  // ----------------------------------------------------------------
  assign ci_ok = (h_word == PTI_AIS_WORD)
                 || (pti_flag(h_word[PTI_FLAG_MSB:PTI_FLAG_LSB],
                              PTI_FLAG_NDF)
                     && (h_word[PTI_OFF_MSB:0] == PTI_CI_OFF)
                     && (!r_reg.sdh
                         || (h_word[PTI_SS_MSB:PTI_SS_LSB]
                             == PTI_SS_SDH)));
  assign pair_lim = r_reg.sdh ? PTI_PAIRS_SDH
                              : PTI_PAIRS_SONET;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup  = psel && !penable;
  assign done   = psel && penable && r_reg.pready;
  assign wr     = done && pwrite;
  assign rd     = done && !pwrite;
  assign mapped = pti_hit(paddr, PTI_CTRL_OFF)
                  || pti_hit(paddr, PTI_ALARM_OFF)
                  || pti_hit(paddr, PTI_PEND_OFF)
                  || pti_hit(paddr, PTI_MASKA_OFF)
                  || pti_hit(paddr, PTI_MASKB_OFF)
                  || pti_hit(paddr, PTI_STAT_OFF);

  assign stat_now[PTI_AIS_BIT] = r_reg.state == PTI_AIS;
  assign stat_now[PTI_LOP_BIT] = r_reg.state == PTI_LOP;
  assign ais_evt = (r_next.state == PTI_AIS) != stat_now[PTI_AIS_BIT];
  assign lop_evt = (r_next.state == PTI_LOP) != stat_now[PTI_LOP_BIT];
  assign evt[PTI_AIS_BIT] = ais_evt;
  assign evt[PTI_LOP_BIT] = lop_evt;
  assign irq_a_want = |(r_reg.pend & r_reg.mask_a);
  assign irq_b_want = |(r_reg.pend & r_reg.mask_b);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;

    if (h_valid) begin
      if (h_first) begin
        r_next.prim_word = h_word;
        r_next.pair_idx  = 8'h01;
        r_next.concat_pointer_bad  = 1'b0;
      end else begin
        if ((r_reg.pair_idx < pair_lim) && !ci_ok) begin
          r_next.concat_pointer_bad = 1'b1;
        end
        if (r_reg.pair_idx != 8'hFF) begin
          r_next.pair_idx = r_reg.pair_idx + 8'h01;
        end
      end
    end

    if (frame_tick) begin
      if (r_reg.hold_cnt != 2'h0) begin
        r_next.hold_cnt = r_reg.hold_cnt - 2'h1;
      end
      if (norm_ok) begin
        if ((off == r_reg.cand_ptr) && (r_reg.norm_cnt != 2'h0)) begin
          if (r_reg.norm_cnt != PTI_NORM_PERSIST) begin
            r_next.norm_cnt = r_reg.norm_cnt + 2'h1;
          end
        end else begin
          r_next.norm_cnt = 2'h1;
        end
        r_next.cand_ptr = off;
      end else begin
        r_next.norm_cnt = 2'h0;
      end
      if (is_ais) begin
        if (r_reg.ais_cnt != PTI_AIS_PERSIST) begin
          r_next.ais_cnt = r_reg.ais_cnt + 2'h1;
        end
      end else begin
        r_next.ais_cnt = 2'h0;
      end
      if (ptr_valid) begin
        r_next.inv_cnt = 4'h0;
      end else if (r_reg.inv_cnt != PTI_LOP_PERSIST) begin
        r_next.inv_cnt = r_reg.inv_cnt + 4'h1;
      end

      if (ndf_ok && (r_reg.state != PTI_LOP)) begin
        r_next.state    = PTI_NORM;
        r_next.cur_ptr  = off;
        r_next.hold_cnt = PTI_HOLD_FRAMES;
        r_next.inv_cnt  = 4'h0;
      end else if (inc_ok) begin
        r_next.cur_ptr  = (r_reg.cur_ptr == PTI_OFF_MAX) ? 10'h000
                          : r_reg.cur_ptr + 10'h001;
        r_next.hold_cnt = PTI_HOLD_FRAMES;
      end else if (dec_ok) begin
        r_next.cur_ptr  = (r_reg.cur_ptr == 10'h000) ? PTI_OFF_MAX
                          : r_reg.cur_ptr - 10'h001;
        r_next.hold_cnt = PTI_HOLD_FRAMES;
      end else if (r_next.norm_cnt == PTI_NORM_PERSIST) begin
        r_next.state   = PTI_NORM;
        r_next.cur_ptr = off;
        r_next.inv_cnt = 4'h0;
      end else if ((r_next.ais_cnt == PTI_AIS_PERSIST)
                   && (r_reg.state != PTI_AIS)) begin
        r_next.state   = PTI_AIS;
        r_next.inv_cnt = 4'h0;
      end else if ((r_next.inv_cnt == PTI_LOP_PERSIST)
                   && (r_reg.state != PTI_LOP)) begin
        r_next.state   = PTI_LOP;
        r_next.inv_cnt = 4'h0;
      end
    end

    // latched alarm shows the event, then the status on the next read
    r_next.latch = (rd && pti_hit(paddr, PTI_ALARM_OFF))
                   ? stat_now : r_reg.latch;
    r_next.latch = r_next.latch | evt;
    // a new event beats the read that clears the pending flag
    r_next.pend  = (rd && pti_hit(paddr, PTI_PEND_OFF))
                   ? 2'h0 : r_reg.pend;
    r_next.pend  = r_next.pend | evt;
    r_next.irq_a = irq_a_want;
    r_next.irq_b = irq_b_want;

    if (wr && pti_hit(paddr, PTI_CTRL_OFF)) begin
      r_next.sdh = pwdata[PTI_SDH_BIT];
    end
    if (wr && pti_hit(paddr, PTI_MASKA_OFF)) begin
      r_next.mask_a = pwdata[1:0];
    end
    if (wr && pti_hit(paddr, PTI_MASKB_OFF)) begin
      r_next.mask_b = pwdata[1:0];
    end

    // read data is fetched in setup, so every access takes one wait-free
    // access cycle
    r_next.pready  = setup;
    r_next.pslverr = setup && !mapped;
    if (setup) begin
      r_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (pti_hit(paddr, PTI_CTRL_OFF)) begin
          r_next.prdata[PTI_SDH_BIT] = r_reg.sdh;
        end
        if (pti_hit(paddr, PTI_ALARM_OFF)) begin
          r_next.prdata[1:0] = r_reg.latch;
        end
        if (pti_hit(paddr, PTI_PEND_OFF)) begin
          r_next.prdata[1:0] = r_reg.pend;
        end
        if (pti_hit(paddr, PTI_MASKA_OFF)) begin
          r_next.prdata[1:0] = r_reg.mask_a;
        end
        if (pti_hit(paddr, PTI_MASKB_OFF)) begin
          r_next.prdata[1:0] = r_reg.mask_b;
        end
        if (pti_hit(paddr, PTI_STAT_OFF)) begin
          r_next.prdata[PTI_STAT_PTR_LSB +: 10] = r_reg.cur_ptr;
          r_next.prdata[PTI_STAT_ST_LSB +: 2]   = r_reg.state;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg        <= '0;
      r_reg.state  <= PTI_LOP;
      r_reg.sdh    <= PTI_SDH_RST;
      r_reg.mask_a <= PTI_MASK_RST;
      r_reg.mask_b <= PTI_MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata             = r_reg.prdata;
  assign pready             = r_reg.pready;
  assign pslverr            = r_reg.pslverr;
  assign wan_irq_out_a      = r_reg.irq_a;
  assign wan_irq_out_b      = r_reg.irq_b;
  assign ptr_state          = r_reg.state;
  assign ptr_value          = r_reg.cur_ptr;
  assign path_ais_alarm     = r_reg.state == PTI_AIS;
  assign pointer_loss_alarm = r_reg.state == PTI_LOP;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ais_frame;
    frame_tick && is_ais;
  endsequence

  sequence s_third_ais;
    s_ais_frame and ((r_reg.ais_cnt == 2'h2) && (r_reg.state == PTI_NORM)
    && !ndf_ok && !inc_ok && !dec_ok);
  endsequence

  property p_ais_enter;
    s_third_ais |=> (ptr_state == PTI_AIS) ##1 path_ais_alarm;
  endproperty
  a_ais_enter: assert property (p_ais_enter)
    else $error("third AIS frame did not enter AIS");

  property p_lop_enter;
    frame_tick && !ptr_valid && !ndf_ok && !norm_ok && (r_reg.inv_cnt == 4'h7)
    && (r_reg.state == PTI_AIS) |=> pointer_loss_alarm;
  endproperty
  a_lop_enter: assert property (p_lop_enter)
    else $error("eighth invalid frame did not enter LOP");

  property p_ndf_adopt;
    frame_tick && ndf_ok && (r_reg.state != PTI_LOP)
    |=> (ptr_state == PTI_NORM) && (ptr_value == $past(off))
        && (r_reg.hold_cnt == PTI_HOLD_FRAMES);
  endproperty
  a_ndf_adopt: assert property (p_ndf_adopt)
    else $error("new data pointer not adopted");

  property p_hold;
    (r_reg.hold_cnt != 2'h0) |-> !inc_ok && !dec_ok;
  endproperty
  a_hold: assert property (p_hold)
    else $error("justification accepted during hold");

  property p_sdh_both;
    r_reg.sdh && (i_inv >= 4'h3) && (d_inv >= 4'h3)
    |-> !inc_ok && !dec_ok;
  endproperty
  a_sdh_both: assert property (p_sdh_both)
    else $error("SDH double inversion acted on");

  property p_ais_pend;
    $changed(path_ais_alarm) |-> r_reg.pend[PTI_AIS_BIT]
                                 && r_reg.latch[PTI_AIS_BIT];
  endproperty
  a_ais_pend: assert property (p_ais_pend)
    else $error("AIS change not latched");

  property p_lop_pend;
    $changed(pointer_loss_alarm) |-> r_reg.pend[PTI_LOP_BIT]
                                     && r_reg.latch[PTI_LOP_BIT];
  endproperty
  a_lop_pend: assert property (p_lop_pend)
    else $error("LOP change not latched");

  property p_irq;
    ##1 (wan_irq_out_a == $past(irq_a_want))
        && (wan_irq_out_b == $past(irq_b_want));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow masked pending");

  property p_inc_step;
    frame_tick && inc_ok && !ndf_ok && (r_reg.cur_ptr != PTI_OFF_MAX)
    |=> (ptr_value == $past(r_reg.cur_ptr) + 10'h001)
        && (ptr_state == PTI_NORM);
  endproperty
  a_inc_step: assert property (p_inc_step)
    else $error("increment did not step pointer");

endmodule

// [pti_pkg.sv]
// constants and types for the receive payload pointer interpreter
//
// Overview of operation
// - flag near 0110, offset 0..782: normal pointer
// - flag near 1001, offset 0..782: new data
// - three 0xFFFF frames enter AIS
// - increment: normal flag, I bits inverted
// - decrement: normal flag, D bits inverted
// - size bits checked only in SDH mode
// - no justification three frames after adjustment
// - SONET increment: eight of ten bits agree
// - SONET decrement: eight of ten bits agree
// - SDH increment: I inverted >=3, D <=2
// - SDH decrement: D inverted >=3, I <=2
// - SDH both majorities inverted: no action
// - three-state machine: normal, lost, AIS
// - one new-data frame enters normal state, except from loss of pointer
// - three equal normal pointers enter normal
// - eight invalid frames enter loss of pointer
// - valid justification moves pointer by one
// - in AIS only AIS pointers count valid
// - in normal, matching pointer also valid
// - AIS change sets latched alarm and pending
// - LOP change sets latched alarm and pending
// - word fields: flag, size, offset
// - SDH checks 64 pairs, SONET all 192
// - first pair primary, others concatenation
package pti_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  PTI_CTRL_OFF     = 8'h00;
  localparam logic [7:0]  PTI_ALARM_OFF    = 8'h04;
  localparam logic [7:0]  PTI_PEND_OFF     = 8'h08;
  localparam logic [7:0]  PTI_MASKA_OFF    = 8'h0C;
  localparam logic [7:0]  PTI_MASKB_OFF    = 8'h10;
  localparam logic [7:0]  PTI_STAT_OFF     = 8'h14;
  localparam int          PTI_SDH_BIT      = 0;
  localparam int          PTI_LOP_BIT      = 0;
  localparam int          PTI_AIS_BIT      = 1;
  localparam int          PTI_STAT_PTR_LSB = 0;
  localparam int          PTI_STAT_ST_LSB  = 12;
  localparam logic        PTI_SDH_RST      = 1'b0;
  localparam logic [1:0]  PTI_MASK_RST     = 2'h0;

  // ----------------------------------------------------------------
  // pointer word layout and codes
  // ----------------------------------------------------------------
  localparam int          PTI_FLAG_MSB     = 15;
  localparam int          PTI_FLAG_LSB     = 12;
  localparam int          PTI_SS_MSB       = 11;
  localparam int          PTI_SS_LSB       = 10;
  localparam int          PTI_OFF_MSB      = 9;
  localparam logic [3:0]  PTI_FLAG_NORM    = 4'h6;
  localparam logic [3:0]  PTI_FLAG_NDF     = 4'h9;
  localparam logic [3:0]  PTI_FLAG_AGREE   = 4'h3;
  localparam logic [1:0]  PTI_SS_SDH       = 2'h2;
  localparam logic [15:0] PTI_AIS_WORD     = 16'hFFFF;
  localparam logic [9:0]  PTI_OFF_MAX      = 10'h30E;
  localparam logic [9:0]  PTI_CI_OFF       = 10'h3FF;
  localparam logic [9:0]  PTI_I_MASK       = 10'h2AA;
  localparam logic [9:0]  PTI_D_MASK       = 10'h155;
  localparam logic [7:0]  PTI_PAIRS_SONET  = 8'hC0;
  localparam logic [7:0]  PTI_PAIRS_SDH    = 8'h40;

  // ----------------------------------------------------------------
  // bit and frame counts
  // ----------------------------------------------------------------
  localparam logic [3:0]  PTI_OFF_BITS     = 4'hA;
  localparam logic [3:0]  PTI_SONET_AGREE  = 4'h8;
  localparam logic [3:0]  PTI_SDH_MAJ      = 4'h3;
  localparam logic [3:0]  PTI_SDH_MIN      = 4'h2;
  localparam logic [1:0]  PTI_NORM_PERSIST = 2'h3;
  localparam logic [1:0]  PTI_AIS_PERSIST  = 2'h3;
  localparam logic [3:0]  PTI_LOP_PERSIST  = 4'h8;
  localparam logic [1:0]  PTI_HOLD_FRAMES  = 2'h3;

  typedef enum logic [1:0] {
    PTI_NORM = 2'b00,
    PTI_LOP  = 2'b01,
    PTI_AIS  = 2'b11
  } pti_state_type;

  typedef struct packed {
    pti_state_type state;
    logic [9:0]    cur_ptr;
    logic [9:0]    cand_ptr;
    logic [1:0]    norm_cnt;
    logic [1:0]    ais_cnt;
    logic [3:0]    inv_cnt;
    logic [1:0]    hold_cnt;
    logic [15:0]   prim_word;
    logic [7:0]    pair_idx;
    logic          concat_pointer_bad;
    logic          sdh;
    logic [1:0]    mask_a;
    logic [1:0]    mask_b;
    logic [1:0]    latch;
    logic [1:0]    pend;
    logic          irq_a;
    logic          irq_b;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } pti_regs_type;

endpackage

// [pti_frame_src.sv]
// far-side frame source: one primary pointer pair, 191 more pairs, then tick
`timescale 1ns/10ps
module pti_frame_src
  import pti_pkg::*;
(
  input  wire logic        pclk,       // shared clock
  input  wire logic        presetn,    // async reset
  input  wire logic        start,      // send one frame
  input  wire logic [15:0] prim,       // primary pointer word
  input  wire logic [15:0] ci,         // word for the other pairs
  output logic             h_valid,    // pair strobe
  output logic             h_first,    // primary pair marker
  output logic [15:0]      h_word,     // pair word
  output logic             frame_tick, // end of frame
  output logic             busy        // frame in progress
);
  logic [8:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      cnt        <= 9'h000;
      h_valid    <= 1'b0;
      h_first    <= 1'b0;
      frame_tick <= 1'b0;
      h_word     <= 16'h0000;
    end else begin
      h_first    <= busy && cnt == 9'h000;
      h_valid    <= busy && cnt < 9'h0C0;
      frame_tick <= busy && cnt == 9'h0C0;
      // idle word toggles so a stale value is never mistaken for a pair
      h_word     <= (!busy || cnt >= 9'h0C0) ? ~h_word :
                    (cnt == 9'h000 ? prim : ci);
      if (start) begin
        busy <= 1'b1;
        cnt  <= 9'h000;
      end else if (busy) begin
        cnt <= cnt + 9'h001;
        if (cnt == 9'h0C0) busy <= 1'b0;
      end
    end
  end
endmodule

// [tb_pti_pointer_interp.sv]
// self-checking bench for the receive pointer interpreter
`timescale 1ns/10ps
module tb_pti_pointer_interp;
  import pti_pkg::*;
  typedef struct {logic [15:0] w; int n; logic [1:0] st; logic [9:0] p;}
    pti_row_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        h_valid, h_first, frame_tick, busy, start, irq_a, irq_b;
  logic        ais, lop, err;
  logic [15:0] h_word, prim, ci;
  logic [1:0]  ptr_state;
  logic [9:0]  ptr_value;
  int          fail_count, samples_checked;
  pti_row_type rows [12] = '{
    '{16'h620A, 2, 2'h1, 10'h000}, '{16'h620A, 1, 2'h0, 10'h20A},
    '{16'h60A1, 1, 2'h0, 10'h20B}, '{16'h60A1, 1, 2'h0, 10'h20B},
    '{16'h620B, 2, 2'h0, 10'h20B}, '{16'h635E, 1, 2'h0, 10'h20A},
    '{16'h8123, 1, 2'h0, 10'h123}, '{16'hFFFF, 2, 2'h0, 10'h123},
    '{16'hFFFF, 1, 2'h3, 10'h123}, '{16'h9050, 1, 2'h0, 10'h050},
    '{16'h63FF, 7, 2'h0, 10'h050}, '{16'h63FF, 1, 2'h1, 10'h050}};

  always #2 pclk = ~pclk;

  pti_pointer_interp i_pti_pointer_interp (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .h_valid(h_valid), .h_first(h_first), .h_word(h_word),
    .frame_tick(frame_tick), .wan_irq_out_a(irq_a), .wan_irq_out_b(irq_b),
    .ptr_state(ptr_state), .ptr_value(ptr_value), .path_ais_alarm(ais),
    .pointer_loss_alarm(lop));
  pti_frame_src i_pti_frame_src (.pclk(pclk), .presetn(presetn),
    .start(start), .prim(prim), .ci(ci), .h_valid(h_valid),
    .h_first(h_first), .h_word(h_word), .frame_tick(frame_tick),
    .busy(busy));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      results();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [15:0] w, input int reps);
    int n;
    repeat (reps) begin
      @(posedge pclk);
      prim  <= w;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (busy !== 1'b0 && n < 400);
      if (n >= 400) begin
        fail_count++;
        results();
      end
      repeat (2) @(posedge pclk);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; start = 0; prim = 16'h0;
    ci = 16'h93FF; fail_count = 0; samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({16'h0, irq_a, irq_b, ptr_state, lop, ais, ptr_value},
        {16'h0, 6'h06, 10'h000}, "reset outputs");
    $display("reset test done");
    apb(1'b1, PTI_MASKA_OFF, 32'h3);
    apb(1'b1, PTI_MASKB_OFF, 32'h0);
    apb(1'b0, PTI_PEND_OFF, 32'h0);
    foreach (rows[i]) begin
      run(rows[i].w, rows[i].n);
      chk({20'h0, ptr_state, ptr_value}, {20'h0, rows[i].st, rows[i].p},
          "table row");
    end
    $display("sonet table done");
    chk({30'h0, irq_a, irq_b}, 32'h2, "irq before read");
    apb(1'b0, PTI_PEND_OFF, 32'h0);
    chk(rd, 32'h3, "pending flags");
    repeat (2) @(posedge pclk);
    chk({30'h0, irq_a, irq_b}, 32'h0, "irq after read");
    apb(1'b0, PTI_ALARM_OFF, 32'h0);
    chk(rd, 32'h3, "alarm event");
    apb(1'b0, PTI_ALARM_OFF, 32'h0);
    chk(rd, 32'h1, "alarm status");
    apb(1'b0, 8'h20, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b0, PTI_STAT_OFF, 32'h0);
    chk(rd, 32'h1050, "status word");
    $display("register test done");
    // sdh: size bits must read 10 in primary and indication pairs
    apb(1'b1, PTI_CTRL_OFF, 32'h1);
    ci <= 16'h9BFF;
    run(16'h620A, 3);
    chk({30'h0, ptr_state}, 32'h1, "sdh size mismatch");
    run(16'h6A0A, 3);
    chk({20'h0, ptr_state, ptr_value}, 32'h020A, "sdh normal");
    run(16'h68AA, 1);
    chk({22'h0, ptr_value}, 32'h020B, "sdh increment");
    $display("sdh test done");
    run(16'hFFFF, 3);
    chk({30'h0, ptr_state}, 32'h3, "sdh ais entry");
    // a matching normal pointer still counts invalid while in AIS
    run(16'h6A0B, 2);
    run(16'h63FF, 6);
    chk({30'h0, ptr_state}, 32'h1, "ais to lop");
    run(16'h6A0B, 3);
    run(16'h6B5E, 1);
    chk({20'h0, ptr_state, ptr_value}, 32'h020A, "sdh decrement");
    apb(1'b0, PTI_PEND_OFF, 32'h0);
    chk(rd, 32'h3, "pending after ais");
    // interrupt B now follows the AIS flag only
    apb(1'b1, PTI_MASKB_OFF, 32'h2);
    ci <= 16'h9BFE;
    run(16'h6A0A, 8);
    chk({30'h0, ptr_state}, 32'h1, "bad concatenation");
    chk({30'h0, irq_a, irq_b}, 32'h2, "irq b masked");
    $display("alarm path test done");
    results();
  end
endmodule
